// file: rtl/fns_register_bank.sv
// Purpose: programming registers and status logic of the synthesizer
// Assumes: load strobe is held high at least one link clock edge
// Notes: phase error flags come from the comparator, one pulse per cycle
`timescale 1ns/10ps
module fns_register_bank (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic link_clk,
  input wire logic serial_data,
  input wire logic load_strobe,
  input wire fns_pkg::fns_phase_t phase_in,
  input wire logic comp_cycle,
  input wire logic ndiv_out,
  input wire logic rdiv_out,
  output fns_pkg::fns_feedback_t feedback,
  output fns_pkg::fns_reference_t reference,
  output fns_pkg::fns_control_t control,
  output logic [10:0] noise_word,
  output logic [3:0] pump_current_eff,
  output logic counters_reset,
  output logic pump_off,
  output logic lock_detect,
  output logic test_out,
  output logic test_out_oe_n
);
  import fns_pkg::*;

  logic [WORD_W-1:0] word;
  logic word_toggle;
  logic [2:0] tog_sync;
  logic [WORD_W-1:0] word_hold;
  logic [11:0] den_pending;
  logic [LOCK_CNT_W-1:0] lock_count;
  logic cycle_d;

  fns_shift_port #(.W(WORD_W)) u_port (
    .link_clk(link_clk),
    .rst_n(rst_n),
    .serial_data(serial_data),
    .load_strobe(load_strobe),
    .word(word),
    .word_toggle(word_toggle)
  );

  // Toggle crosses on three flops; word is stable by then
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tog_sync <= 3'h0;
    end else begin
      tog_sync <= {tog_sync[1:0], word_toggle};
    end
  end
  wire word_event = tog_sync[2] ^ tog_sync[1];

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      word_hold <= '0;
    end else if (word_event) begin
      word_hold <= word;
    end
  end

  wire [1:0] sel = word_hold[1:0];
  logic wr_pulse;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_pulse <= 1'b0;
    end else begin
      wr_pulse <= word_event;
    end
  end
  wire wr_feedback = wr_pulse && sel == SEL_FEEDBACK;
  wire wr_reference = wr_pulse && sel == SEL_REFERENCE;
  wire wr_control = wr_pulse && sel == SEL_CONTROL;
  wire wr_noise = wr_pulse && sel == SEL_NOISE;
  wire load_ctl = word_hold[LOAD_BIT];
  wire [11:0] den_field = word_hold[DEN_LSB +: NUMERATOR_VALUE_W];

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      feedback <= '0;
    end else if (wr_feedback) begin
      feedback.quick_settle <= word_hold[QUICK_BIT];
      feedback.int_value <= word_hold[INT_LSB +: INT_W];
      feedback.numerator_value <= word_hold[NUMERATOR_VALUE_LSB +: NUMERATOR_VALUE_W];
    end
  end

  // Denominator waits for the next feedback write
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reference <= '0;
      den_pending <= 12'h000;
    end else begin
      if (wr_reference) begin
        reference.test_output_select <= word_hold[MUX_LSB +: 3];
        reference.prescaler_choice <= word_hold[PRESC_BIT];
        reference.ref_ratio <= word_hold[RDIV_LSB +: RDIV_W];
        if (load_ctl) begin
          reference.resync_delay <= den_field;
        end else begin
          den_pending <= den_field;
        end
      end
      if (wr_feedback) begin
        reference.denominator_value <= den_pending;
      end
    end
  end

  // Power-down keeps every stored field untouched
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      control <= '0;
      noise_word <= 11'h000;
    end else begin
      if (wr_control) begin
        control.counter_reset <= word_hold[CNT_RST_BIT];
        control.pump_tristate <= word_hold[CP_TRI_BIT];
        control.power_down <= word_hold[PWR_DN_BIT];
        control.lock_precision_bit <= word_hold[LOCK_PREC_BIT];
        control.pump_current <= word_hold[CP_CUR_LSB +: CP_CUR_W];
      end
      if (wr_noise) begin
        noise_word <= word_hold[NOISE_W-1:0];
      end
    end
  end

  wire next_counters_reset = control.counter_reset | control.power_down;
  wire next_pump_off = control.pump_tristate | control.power_down;
  wire [3:0] next_current = feedback.quick_settle ? CP_CUR_MAX
                          : control.pump_current;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      counters_reset <= 1'b0;
      pump_off <= 1'b0;
      pump_current_eff <= 4'h0;
    end else begin
      counters_reset <= next_counters_reset;
      pump_off <= next_pump_off;
      pump_current_eff <= next_current;
    end
  end

  // Lock detection; comparator cycle arrives as a single-cycle strobe
  wire [LOCK_CNT_W-1:0] lock_target = control.lock_precision_bit
      ? LOCK_CNT_W'(LOCK_CNT_HIGH) : LOCK_CNT_W'(LOCK_CNT_LOW);
  wire lock_clear = control.power_down | wr_feedback
                  | (comp_cycle & phase_in.phase_bad);
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      lock_count <= '0;
      lock_detect <= 1'b0;
      cycle_d <= 1'b0;
    end else begin
      cycle_d <= comp_cycle;
      if (lock_clear) begin
        lock_count <= '0;
        lock_detect <= 1'b0;
      end else if (comp_cycle) begin
        if (!phase_in.phase_ok) begin
          lock_count <= '0;
        end else if (lock_count + 1'b1 >= lock_target) begin
          lock_detect <= 1'b1;
          lock_count <= lock_target;
        end else begin
          lock_count <= lock_count + 1'b1;
        end
      end
    end
  end

  // Divider outputs run on their own clocks; three flops, then agreement
  logic [2:0] ndiv_sync;
  logic [2:0] rdiv_sync;
  logic ndiv_clean;
  logic rdiv_clean;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ndiv_sync <= 3'h0;
      rdiv_sync <= 3'h0;
      ndiv_clean <= 1'b0;
      rdiv_clean <= 1'b0;
    end else begin
      ndiv_sync <= {ndiv_sync[1:0], ndiv_out};
      rdiv_sync <= {rdiv_sync[1:0], rdiv_out};
      if (ndiv_sync[2] == ndiv_sync[1]) begin
        ndiv_clean <= ndiv_sync[2];
      end
      if (rdiv_sync[2] == rdiv_sync[1]) begin
        rdiv_clean <= rdiv_sync[2];
      end
    end
  end

  logic next_test;
  logic next_oe_n;
  always_comb begin
    next_test = 1'b0;
    next_oe_n = 1'b0;
    case (reference.test_output_select)
      MUX_TRISTATE: next_oe_n = 1'b1;
      MUX_LOCK: next_test = lock_detect;
      MUX_NDIV: next_test = ndiv_clean;
      MUX_HIGH: next_test = 1'b1;
      MUX_RDIV: next_test = rdiv_clean;
      MUX_LOCK_OD: next_oe_n = lock_detect;
      MUX_SERIAL: next_test = word_hold[WORD_W-1];
      MUX_QUICK_SW: next_oe_n = !feedback.quick_settle;
      default: next_oe_n = 1'b1;
    endcase
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      test_out <= 1'b0;
      test_out_oe_n <= 1'b1;
    end else begin
      test_out <= next_test;
      test_out_oe_n <= next_oe_n;
    end
  end

  a_word_routes: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr_control |=> control.power_down == $past(word_hold[PWR_DN_BIT]))
    else $error("control word not stored");
  a_den_buffer: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr_reference && !load_ctl && !wr_feedback |=>
      $stable(reference.denominator_value))
    else $error("denominator changed early");
  a_resync_load: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr_reference && load_ctl |=> $stable(den_pending))
    else $error("resync write touched denominator");
  a_int_field: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr_feedback |=> feedback.int_value == $past(word_hold[22:14]))
    else $error("integer field wrong");
  a_quick_current: assert property (@(posedge ref_clk) disable iff (!rst_n)
    feedback.quick_settle |=> pump_current_eff == CP_CUR_MAX)
    else $error("quick settle not max");
  a_pwr_down: assert property (@(posedge ref_clk) disable iff (!rst_n)
    control.power_down |=> pump_off && counters_reset && !lock_detect)
    else $error("power down effects missing");
  a_reset_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
    control.counter_reset |=> counters_reset)
    else $error("counters not held");
  a_tri_pump: assert property (@(posedge ref_clk) disable iff (!rst_n)
    control.pump_tristate |=> pump_off)
    else $error("pump not floated");
  a_lock_loss: assert property (@(posedge ref_clk) disable iff (!rst_n)
    comp_cycle && phase_in.phase_bad |=> !lock_detect)
    else $error("lock held after large error");
  a_lock_count: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(lock_detect) |-> $past(comp_cycle) &&
      lock_count == lock_target)
    else $error("lock without full count");

  // Field routing of feedback, reference and noise words
  a_fb_route: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr_feedback |=> feedback.numerator_value ==
      $past(word_hold[NUMERATOR_VALUE_LSB +: NUMERATOR_VALUE_W]))
    else $error("feedback word not stored");
  a_ref_route: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr_reference |=> reference.ref_ratio ==
      $past(word_hold[RDIV_LSB +: RDIV_W]))
    else $error("reference word not stored");
  a_noise_route: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr_noise |=> noise_word == $past(word_hold[NOISE_W-1:0]))
    else $error("noise word not stored");
  a_mux_select: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr_reference |=> reference.test_output_select ==
      $past(word_hold[MUX_LSB +: 3]))
    else $error("test select not stored");
  a_den_active: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr_feedback |=> reference.denominator_value == $past(den_pending))
    else $error("pending denominator not applied");
  a_resync_value: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr_reference && load_ctl |=> reference.resync_delay == $past(den_field))
    else $error("resync delay not stored");

  // Outputs that follow stored settings
  a_quick_switch: assert property (@(posedge ref_clk) disable iff (!rst_n)
    reference.test_output_select == MUX_QUICK_SW && feedback.quick_settle
      |=> !test_out_oe_n && !test_out)
    else $error("quick switch not pulled low");
  a_tristate_out: assert property (@(posedge ref_clk) disable iff (!rst_n)
    reference.test_output_select == MUX_TRISTATE |=> test_out_oe_n)
    else $error("test output not floating");
  a_high_out: assert property (@(posedge ref_clk) disable iff (!rst_n)
    reference.test_output_select == MUX_HIGH |=> test_out && !test_out_oe_n)
    else $error("test output not high");
  a_prog_current: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !feedback.quick_settle |=> pump_current_eff == $past(control.pump_current))
    else $error("programmed current not used");
  a_pd_retain: assert property (@(posedge ref_clk) disable iff (!rst_n)
    control.power_down && !wr_pulse |=>
      $stable(feedback) && $stable(reference) && $stable(noise_word))
    else $error("registers lost in power down");
  a_prec_count: assert property (@(posedge ref_clk) disable iff (!rst_n)
    control.lock_precision_bit && $rose(lock_detect) |->
      lock_count == LOCK_CNT_W'(LOCK_CNT_HIGH))
    else $error("precise lock without 40 cycles");

  c_lock: cover property (@(posedge ref_clk) $rose(lock_detect));
  c_quick_sw: cover property (@(posedge ref_clk)
    reference.test_output_select == MUX_QUICK_SW && feedback.quick_settle);
  c_resync: cover property (@(posedge ref_clk) wr_reference && load_ctl);
  c_den_load: cover property (@(posedge ref_clk)
    wr_reference ##[1:50] wr_feedback);
  c_pwr: cover property (@(posedge ref_clk) $rose(control.power_down));
endmodule

// file: rtl/fns_pkg.sv
// Purpose: constants and types for the synthesizer register bank
// Assumes: 24-bit words shifted MSB first, latched on load strobe
package fns_pkg;
  localparam int WORD_W = 24;
  localparam logic [1:0] SEL_FEEDBACK = 2'h0;
  localparam logic [1:0] SEL_REFERENCE = 2'h1;
  localparam logic [1:0] SEL_CONTROL = 2'h2;
  localparam logic [1:0] SEL_NOISE = 2'h3;
  localparam int QUICK_BIT = 23;
  localparam int INT_LSB = 14;
  localparam int INT_W = 9;
  localparam int NUMERATOR_VALUE_LSB = 2;
  localparam int NUMERATOR_VALUE_W = 12;
  localparam int LOAD_BIT = 23;
  localparam int MUX_LSB = 20;
  localparam int PRESC_BIT = 18;
  localparam int RDIV_LSB = 14;
  localparam int RDIV_W = 4;
  localparam int DEN_LSB = 2;
  localparam int CTRL_W = 16;
  localparam int CNT_RST_BIT = 2;
  localparam int CP_TRI_BIT = 3;
  localparam int PWR_DN_BIT = 4;
  localparam int LOCK_PREC_BIT = 5;
  localparam int CP_CUR_LSB = 7;
  localparam int CP_CUR_W = 4;
  localparam int NOISE_W = 11;
  localparam logic [3:0] CP_CUR_MAX = 4'hF;
  localparam int LOCK_CNT_LOW = 24;
  localparam int LOCK_CNT_HIGH = 40;
  localparam int LOCK_CNT_W = 6;
  localparam logic [2:0] MUX_TRISTATE = 3'h0;
  localparam logic [2:0] MUX_LOCK = 3'h1;
  localparam logic [2:0] MUX_NDIV = 3'h2;
  localparam logic [2:0] MUX_HIGH = 3'h3;
  localparam logic [2:0] MUX_RDIV = 3'h4;
  localparam logic [2:0] MUX_LOCK_OD = 3'h5;
  localparam logic [2:0] MUX_SERIAL = 3'h6;
  localparam logic [2:0] MUX_LOW = 3'h7;
  localparam logic [2:0] MUX_QUICK_SW = 3'h7;

  typedef struct packed {
    logic quick_settle;
    logic [8:0] int_value;
    logic [11:0] numerator_value;
  } fns_feedback_t;

  typedef struct packed {
    logic [2:0] test_output_select;
    logic prescaler_choice;
    logic [3:0] ref_ratio;
    logic [11:0] denominator_value;
    logic [11:0] resync_delay;
  } fns_reference_t;

  typedef struct packed {
    logic counter_reset;
    logic pump_tristate;
    logic power_down;
    logic lock_precision_bit;
    logic [3:0] pump_current;
  } fns_control_t;

  typedef struct packed {
    logic phase_ok;
    logic phase_bad;
  } fns_phase_t;
endpackage

// file: rtl/fns_shift_port.sv
// Purpose: serial word capture on the link clock, handed over by toggle
// Assumes: serial clock may stop between words
// Notes: word stays stable until the next load strobe
`timescale 1ns/10ps
module fns_shift_port #(
  parameter int W = 24
) (
  input wire logic link_clk,
  input wire logic rst_n,
  input wire logic serial_data,
  input wire logic load_strobe,
  output logic [W-1:0] word,
  output logic word_toggle
);
  import fns_pkg::*;
  logic [W-1:0] shift;
  logic load_seen;

  initial begin
    if (W < 2) $error("word too narrow");
  end

  // MSB enters first, so older bits move up
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      shift <= '0;
      load_seen <= 1'b0;
      word <= '0;
      word_toggle <= 1'b0;
    end else begin
      shift <= {shift[W-2:0], serial_data};
      load_seen <= load_strobe;
      if (load_strobe && !load_seen) begin
        word <= shift;
        word_toggle <= ~word_toggle;
      end
    end
  end
endmodule

// file: test/fns_host_model.sv
// Purpose: host model driving the three-wire programming port
// Assumes: link clock runs only inside a frame, 12 ns period
// Notes: idle data line shows the inverse of the last bit sent
`timescale 1ns/10ps
module fns_host_model (
  output logic link_clk,
  output logic serial_data,
  output logic load_strobe
);
  initial begin
    link_clk = 1'b0;
    serial_data = 1'b1;
    load_strobe = 1'b0;
  end

  // Clock stands still between frames
  task automatic send_word(input logic [23:0] w);
    for (int i = 23; i >= 0; i--) begin
      serial_data = w[i];
      #6 link_clk = 1'b1;
      #6 link_clk = 1'b0;
    end
    load_strobe = 1'b1;
    #6 link_clk = 1'b1;
    #6 link_clk = 1'b0;
    load_strobe = 1'b0;
    // No pull on the line, so do not leave the last bit
    serial_data = ~w[0];
  endtask
endmodule

// file: test/fns_register_bank_tb_top.sv
// Purpose: self-checking bench for the synthesizer register bank
// Assumes: registers settle within ten ref_clk cycles of a load
// Notes: host words are held within the documented limits
`timescale 1ns/10ps
module fns_register_bank_tb_top;
  import fns_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic link_clk, serial_data, load_strobe;
  fns_phase_t phase_in = '0;
  logic comp_cycle = 1'b0;
  logic ndiv_out = 1'b0;
  logic rdiv_out = 1'b0;
  fns_feedback_t feedback;
  fns_reference_t reference;
  fns_control_t control;
  logic [10:0] noise_word;
  logic [3:0] pump_current_eff;
  logic counters_reset, pump_off, lock_detect, test_out, test_out_oe_n;
  int failures = 0;
  int cmp_count = 0;

  always #5 ref_clk = ~ref_clk;

  fns_host_model u_fns_host_model (.link_clk(link_clk),
    .serial_data(serial_data), .load_strobe(load_strobe));

  fns_register_bank u_fns_register_bank (.ref_clk(ref_clk), .rst_n(rst_n),
    .link_clk(link_clk), .serial_data(serial_data),
    .load_strobe(load_strobe), .phase_in(phase_in),
    .comp_cycle(comp_cycle), .ndiv_out(ndiv_out), .rdiv_out(rdiv_out),
    .feedback(feedback), .reference(reference), .control(control),
    .noise_word(noise_word), .pump_current_eff(pump_current_eff),
    .counters_reset(counters_reset), .pump_off(pump_off),
    .lock_detect(lock_detect), .test_out(test_out),
    .test_out_oe_n(test_out_oe_n));

  task automatic check(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic complete_run();
    $display("failures %0d cmp_count %0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // N = 95 keeps the 8/9 minimum; numerator stays below FFF
  function automatic logic [23:0] fb_word(input logic q,
                                          input logic [11:0] n);
    return {q, 9'h05F, n, SEL_FEEDBACK};
  endfunction

  function automatic logic [23:0] ref_word(input logic ld,
      input logic [2:0] m, input logic [11:0] v);
    return {ld, m, 1'b0, 1'b1, 4'hF, v, SEL_REFERENCE};
  endfunction

  // Flags: precision, power-down, pump three-state, counter reset
  function automatic logic [23:0] ctl(input logic [3:0] f);
    return {13'h0000, 4'h9, 1'b0, f, SEL_CONTROL};
  endfunction

  task automatic wr(input logic [23:0] w);
    u_fns_host_model.send_word(w);
    repeat (10) @(negedge ref_clk);
  endtask

  task automatic comp(input logic ok, input logic bad, input int n);
    repeat (n) begin
      @(negedge ref_clk);
      phase_in = {ok, bad};
      comp_cycle = 1'b1;
      @(negedge ref_clk);
      comp_cycle = 1'b0;
    end
  endtask

  task automatic t_divider();
    check("oe_n reset", 32'h1, test_out_oe_n);
    wr(ref_word(1'b0, MUX_NDIV, 12'hFFF));
    check("select", MUX_NDIV, reference.test_output_select);
    check("ratio", 32'hF, reference.ref_ratio);
    check("prescaler", 32'h1, reference.prescaler_choice);
    check("den pending", 32'h0, reference.denominator_value);
    wr(ref_word(1'b1, MUX_NDIV, 12'h123));
    check("resync", 32'h123, reference.resync_delay);
    check("den kept", 32'h0, reference.denominator_value);
    wr(fb_word(1'b1, 12'h800));
    check("int", 32'h05F, feedback.int_value);
    check("num", 32'h800, feedback.numerator_value);
    check("den active", 32'hFFF, reference.denominator_value);
  endtask

  task automatic t_test_out();
    check("fast pump", CP_CUR_MAX, pump_current_eff);
    ndiv_out = 1'b1;
    repeat (6) @(negedge ref_clk);
    check("mux n hi", 32'h1, {test_out_oe_n, test_out});
    ndiv_out = 1'b0;
    repeat (6) @(negedge ref_clk);
    check("mux n lo", 32'h0, {test_out_oe_n, test_out});
    wr(ref_word(1'b0, MUX_QUICK_SW, 12'hFFF));
    check("quick sw on", 32'h0, {test_out_oe_n, test_out});
    wr(fb_word(1'b0, 12'h800));
    check("quick sw off", 32'h1, test_out_oe_n);
  endtask

  task automatic t_control();
    wr(ctl(4'h1));
    check("cnt rst", 32'h2, {counters_reset, pump_off});
    check("prog pump", 32'h9, pump_current_eff);
    wr(ctl(4'h2));
    check("pump tri", 32'h1, {counters_reset, pump_off});
    wr(ctl(4'h4));
    check("pd", 32'h3, {counters_reset, pump_off});
    wr(fb_word(1'b0, 12'h7FF));
    check("pd load", 32'h7FF, feedback.numerator_value);
    wr(ctl(4'h0));
    check("resume", 32'h0, {counters_reset, pump_off});
    check("retained", 32'hFFF, reference.denominator_value);
    wr(24'h0003C7);
    check("noise", 32'h3C7, noise_word);
    check("ctl kept", 32'h9, control.pump_current);
  endtask

  task automatic t_lock();
    comp(1'b1, 1'b0, 23);
    check("lock 23", 32'h0, lock_detect);
    comp(1'b1, 1'b0, 1);
    check("lock 24", 32'h1, lock_detect);
    comp(1'b0, 1'b1, 1);
    check("lock bad", 32'h0, lock_detect);
    comp(1'b1, 1'b0, 24);
    wr(fb_word(1'b0, 12'h7FF));
    check("lock chan", 32'h0, lock_detect);
    wr(ctl(4'h8));
    comp(1'b1, 1'b0, 39);
    check("lock 39", 32'h0, lock_detect);
    comp(1'b1, 1'b0, 1);
    check("lock 40", 32'h1, lock_detect);
    wr(ctl(4'hC));
    check("lock pd", 32'h0, lock_detect);
  endtask

  // Reset in mid-run, then a first word right after release
  task automatic t_reset();
    @(negedge ref_clk);
    rst_n = 1'b0;
    repeat (2) @(negedge ref_clk);
    check("rst lock", 32'h0, lock_detect);
    check("rst oe_n", 32'h1, test_out_oe_n);
    check("rst ctl", 32'h0, control);
    rst_n = 1'b1;
    repeat (2) @(negedge ref_clk);
    rdiv_out = 1'b1;
    wr(ref_word(1'b0, MUX_RDIV, 12'h040));
    check("mux r hi", 32'h1, {test_out_oe_n, test_out});
  endtask

  initial begin
    repeat (10) @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (2) @(negedge ref_clk);
    t_divider();
    t_test_out();
    t_control();
    t_lock();
    t_reset();
    complete_run();
  end

  // Run needs well under 30 us
  initial begin
    #200000;
    failures++;
    complete_run();
  end
endmodule
